// ### rtl/qpb_pkg.sv
// Overview of operation
// - second burst address is first plus one, two-bit
// - read select low at rising edge starts read
// - write select low at rising edge starts write
// - read and write sequencers run independently except on the first edge after idle, where a read blocks the write
// - sequencers advance on true clock edges only
// - read beats leave at t+2.5 and t+3.0
// - controller gives write beats at t and t+0.5
// - same-type commands only every other edge
// - both selects low after idle: read wins
// - finish outstanding work before stopping clocks
// - byte-masked write needs write select low
// - x18 lanes gate nine bits, all high aborts
// - x36 four lanes gate nine bits each
// - reads of buffered write address return buffer
// - read-valid flag stands with the first read beat only
package qpb_pkg;

  localparam int LANE_W      = 9;
  localparam int LANE_MAX    = 4;
  localparam int DATA_W_DEF  = 36;
  localparam int ADDR_W_DEF  = 20;
  localparam int FIFO_DEPTH  = 32;
  localparam int BURST_CNT_W = 2;
  // read command edge to first (complement) beat and second (true) beat
  localparam int READ_FALL_CYC = 2;
  localparam int READ_RISE_CYC = 3;
  localparam int RD_OUTSTAND_W = 2;

  localparam logic [BURST_CNT_W-1:0] BURST_STEP = 2'h1;
  localparam logic [LANE_MAX-1:0]    LANES_OFF  = 4'hf;

  // the low two address bits form a wrapping linear counter
  function automatic logic [ADDR_W_DEF-1:0] burstNext(
    input logic [ADDR_W_DEF-1:0] a
  );
    burstNext = {a[ADDR_W_DEF-1:BURST_CNT_W],
                 a[BURST_CNT_W-1:0] + BURST_STEP};
  endfunction

endpackage

// ### rtl/qpb_if.sv
interface qpb_if #(
  parameter int DATA_W = qpb_pkg::DATA_W_DEF,
  parameter int ADDR_W = qpb_pkg::ADDR_W_DEF
);
  logic              readSel_n;
  logic              writeSel_n;
  logic [ADDR_W-1:0] rdAddr;
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] wrDataRise;
  logic [DATA_W-1:0] wrDataFall;
  // bit 0 rides with the true-clock beat, bit 1 with the complement beat
  logic [1:0]        byteLane0WriteEn_n;
  logic [1:0]        byteLane1WriteEn_n;
  logic [1:0]        byteLane2WriteEn_n;
  logic [1:0]        byteLane3WriteEn_n;
  logic [DATA_W-1:0] readDataFall;
  logic [DATA_W-1:0] readDataRise;
  logic              readDataFallOe;
  logic              readDataRiseOe;
  logic              readValidFlag;

  modport mem (
    input  readSel_n, writeSel_n, rdAddr, wrAddr, wrDataRise, wrDataFall,
    input  byteLane0WriteEn_n, byteLane1WriteEn_n,
    input  byteLane2WriteEn_n, byteLane3WriteEn_n,
    output readDataFall, readDataRise, readDataFallOe, readDataRiseOe,
    output readValidFlag
  );

  modport ctrl (
    output readSel_n, writeSel_n, rdAddr, wrAddr, wrDataRise, wrDataFall,
    output byteLane0WriteEn_n, byteLane1WriteEn_n,
    output byteLane2WriteEn_n, byteLane3WriteEn_n,
    input  readDataFall, readDataRise, readDataFallOe, readDataRiseOe,
    input  readValidFlag
  );
endinterface

// ### rtl/qpb_sram.sv
module qpb_sram #(
  parameter int DATA_W = qpb_pkg::DATA_W_DEF,
  parameter int ADDR_W = qpb_pkg::ADDR_W_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  qpb_if.mem       link
);

  localparam int LANES = DATA_W / qpb_pkg::LANE_W;
  localparam int WORDS = 1 << ADDR_W;

  typedef struct packed {
    logic              prevRead;
    logic              prevWrite;
    logic              prevIdle;
    logic              pendValid;
    logic [ADDR_W-1:0] pendAddr;
    logic [DATA_W-1:0] pendData0;
    logic [DATA_W-1:0] pendData1;
    logic [LANES-1:0]  pendMask0_n;
    logic [LANES-1:0]  pendMask1_n;
    logic              s1Valid;
    logic [DATA_W-1:0] s1Beat0;
    logic [DATA_W-1:0] s1Beat1;
    logic              s2Valid;
    logic [DATA_W-1:0] s2Beat0;
    logic [DATA_W-1:0] s2Beat1;
    logic              s3Valid;
    logic [DATA_W-1:0] s3Beat1;
    logic [DATA_W-1:0] readDataFall;
    logic [DATA_W-1:0] readDataRise;
    logic              readDataFallOe;
    logic              readDataRiseOe;
    logic              readValidFlag;
  } qpb_mem_state_t;

  qpb_mem_state_t st;
  qpb_mem_state_t next_st;

  logic [DATA_W-1:0] memArray [WORDS];

  logic                    rdAccept;
  logic                    wrAccept;
  logic                    commitNow;
  logic [ADDR_W-1:0]       rdAddr1;
  logic [ADDR_W-1:0]       pendAddr1;
  logic [qpb_pkg::LANE_MAX-1:0] laneRise_n;
  logic [qpb_pkg::LANE_MAX-1:0] laneFall_n;
  logic [DATA_W-1:0]       lookBeat0;
  logic [DATA_W-1:0]       lookBeat1;

  // second beat address, kept inside the wrapping two-bit counter
  function automatic logic [ADDR_W-1:0] nextAddr(
    input logic [ADDR_W-1:0] a
  );
    nextAddr = {a[ADDR_W-1:qpb_pkg::BURST_CNT_W],
                a[qpb_pkg::BURST_CNT_W-1:0] + qpb_pkg::BURST_STEP};
  endfunction

  // lane-wise overlay of buffered write data on array data
  function automatic logic [DATA_W-1:0] laneMerge(
    input logic [DATA_W-1:0] base,
    input logic [DATA_W-1:0] over,
    input logic [LANES-1:0]  mask_n
  );
    logic [DATA_W-1:0] r;
    r = base;
    for (int l = 0; l < LANES; l++) begin
      if (!mask_n[l]) begin
        r[l*qpb_pkg::LANE_W +: qpb_pkg::LANE_W] =
          over[l*qpb_pkg::LANE_W +: qpb_pkg::LANE_W];
      end
    end
    laneMerge = r;
  endfunction

  // a word as the array would hold it once the buffered burst lands
  function automatic logic [DATA_W-1:0] coherentWord(
    input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] arrWord,
    input qpb_mem_state_t    s,
    input logic [ADDR_W-1:0] pa1
  );
    logic [DATA_W-1:0] r;
    r = arrWord;
    if (s.pendValid && a == s.pendAddr) begin
      r = laneMerge(r, s.pendData0, s.pendMask0_n);
    end else if (s.pendValid && a == pa1) begin
      r = laneMerge(r, s.pendData1, s.pendMask1_n);
    end
    coherentWord = r;
  endfunction

  always_comb begin
    laneRise_n = {link.byteLane3WriteEn_n[0], link.byteLane2WriteEn_n[0],
                  link.byteLane1WriteEn_n[0], link.byteLane0WriteEn_n[0]};
    laneFall_n = {link.byteLane3WriteEn_n[1], link.byteLane2WriteEn_n[1],
                  link.byteLane1WriteEn_n[1], link.byteLane0WriteEn_n[1]};
  end

  always_comb begin
    next_st = st;

    // a same-type command on the edge right after an accepted one is dropped
    rdAccept = !link.readSel_n && !st.prevRead;
    // the write decision also sees read select: both start together except on the first edge after idle
    wrAccept = !link.writeSel_n && !st.prevWrite
               && !(!link.readSel_n && st.prevIdle);

    next_st.prevRead  = rdAccept;
    next_st.prevWrite = wrAccept;
    next_st.prevIdle  = link.readSel_n && link.writeSel_n;

    rdAddr1   = nextAddr(link.rdAddr);
    pendAddr1 = nextAddr(st.pendAddr);
    lookBeat0 = coherentWord(link.rdAddr, memArray[link.rdAddr],
                             st, pendAddr1);
    lookBeat1 = coherentWord(rdAddr1, memArray[rdAddr1], st, pendAddr1);

    // read pipeline: stage 1 holds looked-up data, stage 3 the last beat
    next_st.s1Valid = rdAccept;
    if (rdAccept) begin
      next_st.s1Beat0 = lookBeat0;
      next_st.s1Beat1 = lookBeat1;
    end
    next_st.s2Valid = st.s1Valid;
    next_st.s2Beat0 = st.s1Beat0;
    next_st.s2Beat1 = st.s1Beat1;
    next_st.s3Valid = st.s2Valid;
    next_st.s3Beat1 = st.s2Beat1;

    // first beat on the complement edge of cycle t+2, second at t+3
    next_st.readDataFallOe = st.s2Valid;
    next_st.readDataRiseOe = st.s3Valid;
    if (st.s2Valid) begin
      next_st.readDataFall = st.s2Beat0;
    end
    if (st.s3Valid) begin
      next_st.readDataRise = st.s3Beat1;
    end
    // flag rises with the first beat and falls as the second beat appears
    next_st.readValidFlag = st.s2Valid;

    // the previous burst only reaches the array when a new write arrives,
    // so the buffer always holds the most recent write
    commitNow = wrAccept && st.pendValid;
    if (wrAccept) begin
      next_st.pendValid   = 1'b1;
      next_st.pendAddr    = link.wrAddr;
      next_st.pendData0   = link.wrDataRise;
      next_st.pendData1   = link.wrDataFall;
      next_st.pendMask0_n = laneRise_n[LANES-1:0];
      next_st.pendMask1_n = laneFall_n[LANES-1:0];
    end
  end

  // no reset on the array: contents are undefined at power-up
  always_ff @(posedge mclk) begin
    if (commitNow) begin
      for (int l = 0; l < LANES; l++) begin
        if (!st.pendMask0_n[l]) begin
          memArray[st.pendAddr][l*qpb_pkg::LANE_W +: qpb_pkg::LANE_W] <=
            st.pendData0[l*qpb_pkg::LANE_W +: qpb_pkg::LANE_W];
        end
        if (!st.pendMask1_n[l]) begin
          memArray[pendAddr1][l*qpb_pkg::LANE_W +: qpb_pkg::LANE_W] <=
            st.pendData1[l*qpb_pkg::LANE_W +: qpb_pkg::LANE_W];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.prevIdle <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign link.readDataFall   = st.readDataFall;
  assign link.readDataRise   = st.readDataRise;
  assign link.readDataFallOe = st.readDataFallOe;
  assign link.readDataRiseOe = st.readDataRiseOe;
  assign link.readValidFlag  = st.readValidFlag;

endmodule

// ### rtl/qpb_ctrl.sv
module qpb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = qpb_pkg::FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic          notFull;
  } qpb_fifo_state_t;

  qpb_fifo_state_t st;
  qpb_fifo_state_t next_st;
  logic [WIDTH-1:0] store [DEPTH];
  logic             push;
  logic             pop;

  always_comb begin
    next_st = st;
    push    = inValid && st.notFull;
    pop     = outReady && (st.count != '0);
    if (push) begin
      next_st.wrPtr = (st.wrPtr == LAST_PTR) ? '0 : st.wrPtr + 1'b1;
    end
    if (pop) begin
      next_st.rdPtr = (st.rdPtr == LAST_PTR) ? '0 : st.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
    next_st.notFull = (next_st.count != FULL_CNT);
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      store[st.wrPtr] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st         <= '0;
      st.notFull <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign inReady  = st.notFull;
  assign outValid = (st.count != '0);
  assign outData  = store[st.rdPtr];

endmodule

module qpb_ctrl #(
  parameter int DATA_W = qpb_pkg::DATA_W_DEF,
  parameter int ADDR_W = qpb_pkg::ADDR_W_DEF,
  parameter int DEPTH  = qpb_pkg::FIFO_DEPTH
) (
  input  wire logic                             mclk,
  input  wire logic                             rst_n,
  input  wire logic                             cmdValid,
  output logic                                  cmdReady,
  input  wire logic                             cmdWrite,
  input  wire logic [ADDR_W-1:0]                cmdAddr,
  input  wire logic [DATA_W-1:0]                cmdData0,
  input  wire logic [DATA_W-1:0]                cmdData1,
  input  wire logic [DATA_W/qpb_pkg::LANE_W-1:0] cmdMask0_n,
  input  wire logic [DATA_W/qpb_pkg::LANE_W-1:0] cmdMask1_n,
  input  wire logic                             holdReq,
  output logic                                  quiescent,
  output logic                                  rdDataValid,
  output logic [DATA_W-1:0]                     rdData0,
  output logic [DATA_W-1:0]                     rdData1,
  qpb_if.ctrl                                   link
);

  localparam int LANES = DATA_W / qpb_pkg::LANE_W;
  localparam int FW    = 1 + ADDR_W + 2 * DATA_W + 2 * LANES;
  localparam int OW    = qpb_pkg::RD_OUTSTAND_W;

  typedef struct packed {
    logic                         readSel_n;
    logic                         writeSel_n;
    logic [ADDR_W-1:0]            rdAddr;
    logic [ADDR_W-1:0]            wrAddr;
    logic [DATA_W-1:0]            wrDataRise;
    logic [DATA_W-1:0]            wrDataFall;
    logic [qpb_pkg::LANE_MAX-1:0] enRise_n;
    logic [qpb_pkg::LANE_MAX-1:0] enFall_n;
    logic [OW-1:0]                rdOutstand;
    logic                         secondBeat;
    logic                         rdDataValid;
    logic [DATA_W-1:0]            rdData0;
    logic [DATA_W-1:0]            rdData1;
    logic                         quiescent;
  } qpb_ctrl_state_t;

  qpb_ctrl_state_t st;
  qpb_ctrl_state_t next_st;

  logic          headValid;
  logic [FW-1:0] headData;
  logic          headWrite;
  logic          issue;

  qpb_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) qpb_fifo_i (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .inValid  (cmdValid),
    .inReady  (cmdReady),
    .inData   ({cmdWrite, cmdAddr, cmdData0, cmdData1,
                cmdMask0_n, cmdMask1_n}),
    .outValid (headValid),
    .outReady (issue),
    .outData  (headData)
  );

  always_comb begin
    next_st   = st;
    headWrite = headData[FW-1];
    // one command per cycle keeps read and write from colliding after idle;
    // hold stops new work so the clock may be stopped once drained
    issue = headValid && !holdReq
            && !(headWrite ? !st.writeSel_n : !st.readSel_n);

    next_st.readSel_n  = 1'b1;
    next_st.writeSel_n = 1'b1;
    next_st.enRise_n   = qpb_pkg::LANES_OFF;
    next_st.enFall_n   = qpb_pkg::LANES_OFF;
    if (issue && headWrite) begin
      next_st.writeSel_n = 1'b0;
      next_st.wrAddr     = headData[FW-2 -: ADDR_W];
      next_st.wrDataRise = headData[2*LANES+2*DATA_W-1 -: DATA_W];
      next_st.wrDataFall = headData[2*LANES+DATA_W-1 -: DATA_W];
      next_st.enRise_n[LANES-1:0] = headData[2*LANES-1 -: LANES];
      next_st.enFall_n[LANES-1:0] = headData[LANES-1:0];
    end else if (issue) begin
      next_st.readSel_n = 1'b0;
      next_st.rdAddr    = headData[FW-2 -: ADDR_W];
    end

    // first beat arrives with the flag, the second one cycle later
    next_st.rdDataValid = 1'b0;
    next_st.secondBeat  = link.readValidFlag;
    if (link.readValidFlag) begin
      next_st.rdData0 = link.readDataFall;
    end
    if (st.secondBeat) begin
      next_st.rdData1     = link.readDataRise;
      next_st.rdDataValid = 1'b1;
    end
    if (issue && !headWrite && !st.secondBeat) begin
      next_st.rdOutstand = st.rdOutstand + 1'b1;
    end else if (st.secondBeat && !(issue && !headWrite)) begin
      next_st.rdOutstand = st.rdOutstand - 1'b1;
    end
    next_st.quiescent = holdReq && (next_st.rdOutstand == '0)
                        && next_st.readSel_n && next_st.writeSel_n;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st            <= '0;
      st.readSel_n  <= 1'b1;
      st.writeSel_n <= 1'b1;
      st.enRise_n   <= qpb_pkg::LANES_OFF;
      st.enFall_n   <= qpb_pkg::LANES_OFF;
    end else begin
      st <= next_st;
    end
  end

  assign link.readSel_n          = st.readSel_n;
  assign link.writeSel_n         = st.writeSel_n;
  assign link.rdAddr             = st.rdAddr;
  assign link.wrAddr             = st.wrAddr;
  assign link.wrDataRise         = st.wrDataRise;
  assign link.wrDataFall         = st.wrDataFall;
  assign link.byteLane0WriteEn_n = {st.enFall_n[0], st.enRise_n[0]};
  assign link.byteLane1WriteEn_n = {st.enFall_n[1], st.enRise_n[1]};
  assign link.byteLane2WriteEn_n = {st.enFall_n[2], st.enRise_n[2]};
  assign link.byteLane3WriteEn_n = {st.enFall_n[3], st.enRise_n[3]};
  assign quiescent   = st.quiescent;
  assign rdDataValid = st.rdDataValid;
  assign rdData0     = st.rdData0;
  assign rdData1     = st.rdData1;

endmodule

// ### test/qpb_properties.sv
module qpb_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic readSel_n,
  input wire logic writeSel_n,
  input wire logic readDataFallOe,
  input wire logic readDataRiseOe,
  input wire logic readValidFlag
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // a read is taken only when the previous edge took none
  logic rdTaken;
  logic rdTakenQ;

  assign rdTaken = !readSel_n && !rdTakenQ;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdTakenQ <= 1'b0;
    end else begin
      rdTakenQ <= rdTaken;
    end
  end

  // a beat launched at edge E+2 is first seen by a property at E+3
  a_read_fall_beat: assert property (
    rdTaken |-> ##3 (readDataFallOe && readValidFlag))
    else $error("first read beat missing after command");
  a_read_rise_beat: assert property (
    rdTaken |-> ##4 (readDataRiseOe && !readValidFlag))
    else $error("second read beat or valid drop out of place");
  a_flag_has_cause: assert property (
    readValidFlag |-> $past(rdTaken, 3))
    else $error("read valid without a taken read");
  a_idle_released: assert property (
    readDataFallOe |-> $past(rdTaken, 3))
    else $error("first beat driven without a read");
  a_rise_has_cause: assert property (
    readDataRiseOe |-> $past(rdTaken, 4))
    else $error("second beat driven without a read");
  a_fall_one_cycle: assert property (
    readDataFallOe |=> !readDataFallOe)
    else $error("first beat stood longer than one cycle");
  a_beats_paired: assert property (
    readDataFallOe |=> readDataRiseOe)
    else $error("second beat did not follow the first");
  a_read_spacing: assert property (
    !readSel_n |=> readSel_n)
    else $error("controller issued reads on adjacent edges");
  a_write_spacing: assert property (
    !writeSel_n |=> writeSel_n)
    else $error("controller issued writes on adjacent edges");
endmodule

// ### test/qpb_tb.sv
module qpb_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DW = 36;
  localparam int AW = 8;
  localparam logic [DW-1:0] DA = 36'h123456789;
  localparam logic [DW-1:0] DB = 36'h0abcdef01;

  logic          mclk;
  logic          rst_n;
  logic          cmdValid;
  logic          cmdReady;
  logic          cmdWrite;
  logic [AW-1:0] cmdAddr;
  logic [DW-1:0] cmdData0;
  logic [DW-1:0] cmdData1;
  logic [3:0]    cmdMask0_n;
  logic [3:0]    cmdMask1_n;
  logic          holdReq;
  logic          quiescent;
  logic          rdDataValid;
  logic [DW-1:0] rdData0;
  logic [DW-1:0] rdData1;
  logic [DW-1:0] last2;
  int            errCount;
  int            nTests;
  int            cycles;
  int            flags2;

  qpb_if #(.DATA_W(DW), .ADDR_W(AW)) link ();
  qpb_if #(.DATA_W(DW), .ADDR_W(AW)) link2 ();

  qpb_ctrl #(.DATA_W(DW), .ADDR_W(AW)) qpb_ctrl_i (
    .mclk(mclk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData0(cmdData0),
    .cmdData1(cmdData1), .cmdMask0_n(cmdMask0_n), .cmdMask1_n(cmdMask1_n),
    .holdReq(holdReq), .quiescent(quiescent), .rdDataValid(rdDataValid),
    .rdData0(rdData0), .rdData1(rdData1), .link(link)
  );
  qpb_sram #(.DATA_W(DW), .ADDR_W(AW)) qpb_sram_i (
    .mclk(mclk), .rst_n(rst_n), .link(link)
  );
  // second device faces the bench, which breaks the controller's rules
  qpb_sram #(.DATA_W(DW), .ADDR_W(AW)) qpb_sram_i2 (
    .mclk(mclk), .rst_n(rst_n), .link(link2)
  );
  qpb_properties qpb_properties_i (
    .mclk(mclk), .rst_n(rst_n), .readSel_n(link.readSel_n),
    .writeSel_n(link.writeSel_n), .readDataFallOe(link.readDataFallOe),
    .readDataRiseOe(link.readDataRiseOe), .readValidFlag(link.readValidFlag)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic finalReport;
    $display("checks %0d errors %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (link2.readValidFlag === 1'b1) flags2++;
    if (link2.readDataFallOe === 1'b1) last2 <= link2.readDataFall;
    if (cycles == 3000) begin
      errCount++;
      $display("ERROR run expected done seen timeout");
      finalReport();
    end
  end

  task automatic check(input string what, input logic [DW-1:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // every push costs at least two cycles, which keeps same-type spacing legal
  task automatic push(input logic wr, input logic [AW-1:0] a,
                      input logic [DW-1:0] d0, d1, input logic [3:0] m0, m1);
    int k;
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdAddr = a;
    cmdData0 = d0;
    cmdData1 = d1;
    cmdMask0_n = m0;
    cmdMask1_n = m1;
    k = 0;
    while (cmdReady !== 1'b1 && k < 100) begin
      @(posedge mclk);
      #1;
      k++;
    end
    @(posedge mclk);
    #1;
    cmdValid = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic readAt(input logic [AW-1:0] a);
    int k;
    push(1'b0, a, '0, '0, 4'hf, 4'hf);
    k = 0;
    while (rdDataValid !== 1'b1 && k < 40) begin
      @(posedge mclk);
      #1;
      k++;
    end
    check("rdDataValid", DW'(rdDataValid), DW'(1));
  endtask

  task automatic testBurstWrap;
    push(1'b1, 8'h03, DA, DB, 4'h0, 4'h0);
    readAt(8'h03);
    check("rdData0", rdData0, DA);
    check("rdData1", rdData1, DB);
    push(1'b1, 8'h13, DB, DA, 4'h0, 4'h0);
    readAt(8'h00);
    check("wrapped beat", rdData0, DB);
  endtask

  task automatic testLanes;
    logic [3:0]    m0;
    logic [3:0]    m1;
    logic [DW-1:0] e0;
    logic [DW-1:0] e1;
    for (int l = 0; l < 5; l++) begin
      m0 = (l == 4) ? 4'hf : ~(4'h1 << l);
      m1 = (l == 4) ? 4'hf : ~(4'h1 << ((l + 1) % 4));
      e0 = (l == 4) ? '0 : 36'h1ff << (9 * l);
      e1 = (l == 4) ? '0 : 36'h1ff << (9 * ((l + 1) % 4));
      push(1'b1, 8'h20, '0, '0, 4'h0, 4'h0);
      push(1'b1, 8'h20, '1, '1, m0, m1);
      readAt(8'h20);
      check("lane beat0", rdData0, e0);
      check("lane beat1", rdData1, e1);
    end
  endtask

  task automatic testFifoFill;
    int n;
    int v;
    holdReq = 1'b1;
    n = 0;
    while (cmdReady === 1'b1 && n < 40) begin
      push(1'b0, 8'h03, '0, '0, 4'hf, 4'hf);
      n++;
    end
    check("fifo entries", DW'(n), DW'(qpb_pkg::FIFO_DEPTH));
    check("quiescent", DW'(quiescent), DW'(1));
    holdReq = 1'b0;
    v = 0;
    repeat (200) begin
      @(posedge mclk);
      #1;
      if (rdDataValid === 1'b1) begin
        v++;
        check("queued read", rdData0, DA);
        check("queued beat1", rdData1, DB);
      end
    end
    check("reads done", DW'(v), DW'(qpb_pkg::FIFO_DEPTH));
  endtask

  task automatic cyc2(input logic r, w, input logic [DW-1:0] d);
    link2.readSel_n = r;
    link2.writeSel_n = w;
    link2.wrDataRise = d;
    link2.wrDataFall = d;
    @(posedge mclk);
    #1;
  endtask

  task automatic testSecondPort;
    cyc2(1'b1, 1'b0, DA);
    cyc2(1'b1, 1'b1, '0);
    cyc2(1'b1, 1'b1, '0);
    // both selects after idle: the write of DB must vanish
    cyc2(1'b0, 1'b0, DB);
    cyc2(1'b1, 1'b1, '0);
    cyc2(1'b0, 1'b1, '0);
    cyc2(1'b0, 1'b1, '0);
    repeat (6) cyc2(1'b1, 1'b1, '0);
    check("port2 reads", DW'(flags2), DW'(2));
    check("port2 data", last2, DA);
  endtask

  initial begin
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr = '0;
    cmdData0 = '0;
    cmdData1 = '0;
    cmdMask0_n = 4'hf;
    cmdMask1_n = 4'hf;
    holdReq = 1'b0;
    link2.readSel_n = 1'b1;
    link2.writeSel_n = 1'b1;
    link2.rdAddr = 8'h05;
    link2.wrAddr = 8'h05;
    link2.wrDataRise = '0;
    link2.wrDataFall = '0;
    link2.byteLane0WriteEn_n = 2'h0;
    link2.byteLane1WriteEn_n = 2'h0;
    link2.byteLane2WriteEn_n = 2'h0;
    link2.byteLane3WriteEn_n = 2'h0;
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    testBurstWrap();
    testLanes();
    testFifoFill();
    testSecondPort();
    finalReport();
  end
endmodule
